// ### verilog/rtd_core.sv
// rtd_core: carrier driver control, registers and modulation path
// assumes an 8-bit register port on the system clock and an
// asynchronous external modulation input
`timescale 1ns/1ps
module rtd_core (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire rtd_pkg::rtd_reg_req_t reg_req,
    output logic [7:0]                 reg_rdata,
    input  wire logic                  internal_envelope_signal,
    input  wire logic                  external_signal_input,
    output rtd_pkg::rtd_pin_t          first_driver_pin,
    output rtd_pkg::rtd_pin_t          second_driver_pin,
    output rtd_pkg::rtd_level_t        level
);
    typedef struct packed {
        logic [7:0]          driver_mode;
        logic [7:0]          carrier_amplitude;
        logic [7:0]          transmit_control;
        logic [7:0]          rdata;
        logic                ext_s1;
        logic                ext_s2;
        logic                prev_mod;
        rtd_pkg::rtd_guard_t guard;
        logic [3:0]          guard_cnt;
        rtd_pkg::rtd_level_t lvl;
    } rtd_core_st_t;

    rtd_core_st_t q;
    rtd_core_st_t d;

    logic       carrier;
    logic       carrier_tick;
    logic [2:0] driver_output_style;
    logic       driver_outputs_on;
    logic       first_output_invert;
    logic       second_output_invert;
    logic [1:0] carrier_level_reduction;
    logic [3:0] overshoot_guard_length;
    logic [1:0] modulation_source_select;
    logic       modulation_invert;
    logic       full_swing;
    logic       mod_src;
    logic       mod_sig;

    // ==========================================================
    // field decode
    assign driver_output_style =
        q.driver_mode[rtd_pkg::DM_STYLE_HI:rtd_pkg::DM_STYLE_LO];
    assign driver_outputs_on   = q.driver_mode[rtd_pkg::DM_OUTPUTS_ON];
    assign first_output_invert = q.driver_mode[rtd_pkg::DM_FIRST_INVERT];
    assign second_output_invert =
        q.driver_mode[rtd_pkg::DM_SECOND_INVERT];
    assign carrier_level_reduction =
        q.carrier_amplitude[rtd_pkg::AMP_REDUCE_HI:rtd_pkg::AMP_REDUCE_LO];
    assign overshoot_guard_length =
        q.transmit_control[rtd_pkg::TC_GUARD_HI:rtd_pkg::TC_GUARD_LO];
    assign modulation_source_select =
        q.transmit_control[rtd_pkg::TC_SRC_HI:rtd_pkg::TC_SRC_LO];
    assign modulation_invert = q.transmit_control[rtd_pkg::TC_MOD_INVERT];
    assign full_swing        = q.transmit_control[rtd_pkg::TC_FULL_SWING];

    assign reg_rdata = q.rdata;
    assign level     = q.lvl;

    function automatic logic [10:0] reduce_mv(input logic [1:0] code);
        case (code)
            2'h0:    reduce_mv = rtd_pkg::REDUCE_MV_0;
            2'h1:    reduce_mv = rtd_pkg::REDUCE_MV_1;
            2'h2:    reduce_mv = rtd_pkg::REDUCE_MV_2;
            default: reduce_mv = rtd_pkg::REDUCE_MV_3;
        endcase
    endfunction

    // ==========================================================
    // modulation source
    always_comb begin
        case (modulation_source_select)
            rtd_pkg::SRC_ENVELOPE: mod_src = internal_envelope_signal;
            rtd_pkg::SRC_EXTERNAL: mod_src = q.ext_s2;
            default:               mod_src = 1'b0;
        endcase
        if (modulation_source_select == rtd_pkg::SRC_ENVELOPE ||
            modulation_source_select == rtd_pkg::SRC_EXTERNAL) begin
            mod_sig = mod_src ^ modulation_invert;
        end else begin
            mod_sig = 1'b0;
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        d.ext_s1 = external_signal_input;
        d.ext_s2 = q.ext_s1;

        if (reg_req.wr) begin
            case (reg_req.addr)
                rtd_pkg::ADDR_DRIVER_MODE:
                    d.driver_mode =
                        reg_req.wdata & rtd_pkg::MASK_DRIVER_MODE;
                rtd_pkg::ADDR_CARRIER_AMPLITUDE:
                    d.carrier_amplitude =
                        reg_req.wdata & rtd_pkg::MASK_CARRIER_AMPLITUDE;
                rtd_pkg::ADDR_TRANSMIT_CONTROL:
                    d.transmit_control =
                        reg_req.wdata & rtd_pkg::MASK_TRANSMIT_CONTROL;
                default: begin
                end
            endcase
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                rtd_pkg::ADDR_DRIVER_MODE:
                    d.rdata = q.driver_mode;
                rtd_pkg::ADDR_CARRIER_AMPLITUDE:
                    d.rdata = q.carrier_amplitude;
                rtd_pkg::ADDR_TRANSMIT_CONTROL:
                    d.rdata = q.transmit_control;
                default:
                    d.rdata = 8'h00;
            endcase
        end

        d.prev_mod = mod_sig;
        case (q.guard)
            rtd_pkg::GRD_IDLE: begin
                if (q.prev_mod && !mod_sig &&
                    overshoot_guard_length != 4'h0) begin
                    d.guard     = rtd_pkg::GRD_RUN;
                    d.guard_cnt = overshoot_guard_length;
                end
            end
            rtd_pkg::GRD_RUN: begin
                if (mod_sig) begin
                    d.guard     = rtd_pkg::GRD_IDLE;
                    d.guard_cnt = 4'h0;
                end else if (carrier_tick) begin
                    d.guard_cnt = q.guard_cnt - 4'h1;
                    if (q.guard_cnt == 4'h1) begin
                        d.guard = rtd_pkg::GRD_IDLE;
                    end
                end
            end
            default: begin
                d.guard     = rtd_pkg::GRD_IDLE;
                d.guard_cnt = 4'h0;
            end
        endcase

        if (full_swing) begin
            d.lvl.reduction_mv = rtd_pkg::REDUCE_MV_NONE;
        end else begin
            d.lvl.reduction_mv = reduce_mv(carrier_level_reduction);
        end
        d.lvl.residual_carrier =
            q.carrier_amplitude[rtd_pkg::AMP_RESID_HI:rtd_pkg::AMP_RESID_LO];
        d.lvl.full_swing = full_swing;
        // guard takes over in the cycle modulation drops, no gap
        d.lvl.modulating = mod_sig || (d.guard == rtd_pkg::GRD_RUN);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q                   <= '0;
            q.driver_mode       <= rtd_pkg::RST_DRIVER_MODE;
            q.carrier_amplitude <= rtd_pkg::RST_CARRIER_AMPLITUDE;
            q.transmit_control  <= rtd_pkg::RST_TRANSMIT_CONTROL;
            q.guard             <= rtd_pkg::GRD_IDLE;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // carrier and pins
    rtd_carrier_div u_div (
        .clock        (clock),
        .rst_n        (rst_n),
        .carrier      (carrier),
        .carrier_tick (carrier_tick)
    );

    // first pin inversion, shared enable, style as written
    rtd_pin_drv u_first (
        .clock      (clock),
        .rst_n      (rst_n),
        .style      (driver_output_style),
        .outputs_on (driver_outputs_on),
        .invert     (first_output_invert),
        .carrier    (carrier),
        .pin        (first_driver_pin)
    );

    rtd_pin_drv u_second (
        .clock      (clock),
        .rst_n      (rst_n),
        .style      (driver_output_style),
        .outputs_on (driver_outputs_on),
        .invert     (second_output_invert),
        .carrier    (carrier),
        .pin        (second_driver_pin)
    );

    // ==========================================================
    // checks
    property p_reserved_zero;
        @(posedge clock) disable iff (!rst_n)
        reg_req.rd && reg_req.addr == rtd_pkg::ADDR_DRIVER_MODE
        |=> reg_rdata[5:4] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved mode bits read nonzero");

    property p_amp_reserved;
        @(posedge clock) disable iff (!rst_n)
        reg_req.rd && reg_req.addr == rtd_pkg::ADDR_CARRIER_AMPLITUDE
        |=> !reg_rdata[5];
    endproperty
    a_amp_reserved: assert property (p_amp_reserved)
        else $error("reserved amplitude bit read nonzero");

    property p_full_swing;
        @(posedge clock) disable iff (!rst_n)
        full_swing |=> level.reduction_mv == 11'h000 && level.full_swing;
    endproperty
    a_full_swing: assert property (p_full_swing)
        else $error("full swing did not clear reduction");

    property p_reduce_max;
        @(posedge clock) disable iff (!rst_n)
        !full_swing && carrier_level_reduction == 2'h3
        |=> level.reduction_mv == 11'h3E8;
    endproperty
    a_reduce_max: assert property (p_reduce_max)
        else $error("reduction code 3 not 1000 mV");

    property p_residual;
        @(posedge clock) disable iff (!rst_n)
        1'b1 |=> level.residual_carrier == $past(q.carrier_amplitude[4:0]);
    endproperty
    a_residual: assert property (p_residual)
        else $error("residual carrier not passed on");

    property p_guard_hold;
        @(posedge clock) disable iff (!rst_n)
        q.prev_mod && !mod_sig && overshoot_guard_length != 4'h0
        && q.guard == rtd_pkg::GRD_IDLE
        |=> level.modulating;
    endproperty
    a_guard_hold: assert property (p_guard_hold)
        else $error("guard did not extend modulation");

    property p_no_source;
        @(posedge clock) disable iff (!rst_n)
        modulation_source_select == rtd_pkg::SRC_NONE && !q.prev_mod
        && q.guard == rtd_pkg::GRD_IDLE |=> !level.modulating;
    endproperty
    a_no_source: assert property (p_no_source)
        else $error("modulation without a source");

    property p_mod_invert;
        @(posedge clock) disable iff (!rst_n)
        modulation_source_select == rtd_pkg::SRC_ENVELOPE
        && modulation_invert && !internal_envelope_signal
        |=> level.modulating;
    endproperty
    a_mod_invert: assert property (p_mod_invert)
        else $error("inverted envelope not modulating");
endmodule // rtd_core

// ### verilog/rtd_pkg.sv
// rtd_pkg: constants and carriers for the carrier-driver control block
// assumes a 100 MHz system clock and an 8-bit register port
package rtd_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_DRIVER_MODE       = 8'h28;
    localparam logic [7:0] ADDR_CARRIER_AMPLITUDE = 8'h29;
    localparam logic [7:0] ADDR_TRANSMIT_CONTROL  = 8'h2A;

    localparam logic [7:0] RST_DRIVER_MODE        = 8'h00;
    localparam logic [7:0] RST_CARRIER_AMPLITUDE  = 8'h00;
    localparam logic [7:0] RST_TRANSMIT_CONTROL   = 8'h00;

    // writable bits; reserved bits read as zero
    localparam logic [7:0] MASK_DRIVER_MODE       = 8'hCF;
    localparam logic [7:0] MASK_CARRIER_AMPLITUDE = 8'hDF;
    localparam logic [7:0] MASK_TRANSMIT_CONTROL  = 8'hFF;

    // ==========================================================
    // field positions
    localparam int DM_SECOND_INVERT = 7;
    localparam int DM_FIRST_INVERT  = 6;
    localparam int DM_OUTPUTS_ON    = 3;
    localparam int DM_STYLE_HI      = 2;
    localparam int DM_STYLE_LO      = 0;
    localparam int AMP_REDUCE_HI    = 7;
    localparam int AMP_REDUCE_LO    = 6;
    localparam int AMP_RESID_HI     = 4;
    localparam int AMP_RESID_LO     = 0;
    localparam int TC_GUARD_HI      = 7;
    localparam int TC_GUARD_LO      = 4;
    localparam int TC_FULL_SWING    = 3;
    localparam int TC_MOD_INVERT    = 2;
    localparam int TC_SRC_HI        = 1;
    localparam int TC_SRC_LO        = 0;

    // ==========================================================
    // driver output style codes
    localparam logic [2:0] STYLE_HIGH_Z     = 3'h0;
    localparam logic [2:0] STYLE_OPEN_DRAIN = 3'h1;
    localparam logic [2:0] STYLE_PUSH_PULL  = 3'h2;
    localparam logic [2:0] STYLE_FIXED_LOW  = 3'h4;
    localparam logic [2:0] STYLE_FIXED_HIGH = 3'h5;

    // modulation source codes
    localparam logic [1:0] SRC_NONE     = 2'h0;
    localparam logic [1:0] SRC_ENVELOPE = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;

    // carrier level reduction below supply, millivolts
    localparam logic [10:0] REDUCE_MV_0 = 11'h064;
    localparam logic [10:0] REDUCE_MV_1 = 11'h0FA;
    localparam logic [10:0] REDUCE_MV_2 = 11'h1F4;
    localparam logic [10:0] REDUCE_MV_3 = 11'h3E8;
    localparam logic [10:0] REDUCE_MV_NONE = 11'h000;

    // ==========================================================
    // timing
    localparam int CLOCK_PERIOD_PS   = 10000;
    localparam int CARRIER_PERIOD_PS = 73746;
    localparam int CARRIER_HALF_CYC_I =
        (CARRIER_PERIOD_PS / (2 * CLOCK_PERIOD_PS)) < 1 ? 1 :
        (CARRIER_PERIOD_PS / (2 * CLOCK_PERIOD_PS));
    localparam logic [3:0] CARRIER_HALF_CYC = 4'(CARRIER_HALF_CYC_I);

    // ==========================================================
    // carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtd_reg_req_t;

    typedef struct packed {
        logic o;
        logic oe;
    } rtd_pin_t;

    typedef struct packed {
        logic [10:0] reduction_mv;
        logic [4:0]  residual_carrier;
        logic        full_swing;
        logic        modulating;
    } rtd_level_t;

    typedef enum logic [1:0] {
        GRD_IDLE = 2'b01,
        GRD_RUN  = 2'b10
    } rtd_guard_t;

endpackage

// ### verilog/rtd_carrier_div.sv
// rtd_carrier_div: carrier phase and per-period tick from the system clock
// assumes one clock domain, asynchronous active-low reset
`timescale 1ns/1ps
module rtd_carrier_div (
    input  wire logic clock,
    input  wire logic rst_n,
    output logic      carrier,
    output logic      carrier_tick
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       phase;
    } rtd_div_st_t;

    rtd_div_st_t q;
    rtd_div_st_t d;
    logic        wrap;

    assign wrap         = (q.cnt == rtd_pkg::CARRIER_HALF_CYC - 4'h1);
    // one tick per carrier period, at the high-to-low edge
    assign carrier_tick = wrap & q.phase;
    assign carrier      = q.phase;

    always_comb begin
        d = q;
        if (wrap) begin
            d.cnt   = 4'h0;
            d.phase = ~q.phase;
        end else begin
            d.cnt = q.cnt + 4'h1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // rtd_carrier_div

// ### verilog/rtd_pin_drv.sv
// rtd_pin_drv: one carrier driver pin, style, enable and inversion
// assumes the carrier phase comes from logic on the same clock
`timescale 1ns/1ps
module rtd_pin_drv (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [2:0]       style,
    input  wire logic             outputs_on,
    input  wire logic             invert,
    input  wire logic             carrier,
    output rtd_pkg::rtd_pin_t     pin
);
    typedef struct packed {
        rtd_pkg::rtd_pin_t p;
    } rtd_drv_st_t;

    rtd_drv_st_t q;
    rtd_drv_st_t d;
    logic        lvl;

    assign lvl = carrier ^ invert;
    assign pin = q.p;

    always_comb begin
        d = '0;
        if (outputs_on) begin
            case (style)
                rtd_pkg::STYLE_OPEN_DRAIN: begin
                    d.p.o  = 1'b0;
                    d.p.oe = ~lvl;
                end
                rtd_pkg::STYLE_PUSH_PULL: begin
                    d.p.o  = lvl;
                    d.p.oe = 1'b1;
                end
                rtd_pkg::STYLE_FIXED_LOW: begin
                    d.p.o  = invert;
                    d.p.oe = 1'b1;
                end
                rtd_pkg::STYLE_FIXED_HIGH: begin
                    d.p.o  = ~invert;
                    d.p.oe = 1'b1;
                end
                default: begin
                    d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // checks
    property p_off_released;
        @(posedge clock) disable iff (!rst_n)
        !outputs_on |=> !pin.oe;
    endproperty
    a_off_released: assert property (p_off_released)
        else $error("pin driven while outputs are off");

    property p_push_pull;
        @(posedge clock) disable iff (!rst_n)
        outputs_on && style == rtd_pkg::STYLE_PUSH_PULL
        |=> pin.oe && pin.o == ($past(carrier) ^ $past(invert));
    endproperty
    a_push_pull: assert property (p_push_pull)
        else $error("push-pull pin does not follow carrier");

    property p_fixed_high;
        @(posedge clock) disable iff (!rst_n)
        outputs_on && style == rtd_pkg::STYLE_FIXED_HIGH
        |=> pin.oe && pin.o == !$past(invert);
    endproperty
    a_fixed_high: assert property (p_fixed_high)
        else $error("fixed high pin level wrong");

    property p_open_drain;
        @(posedge clock) disable iff (!rst_n)
        outputs_on && style == rtd_pkg::STYLE_OPEN_DRAIN
        |=> !pin.o && pin.oe == !($past(carrier) ^ $past(invert));
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain pin drives high or wrong phase");
endmodule // rtd_pin_drv

// ### bench/rtd_antenna_model.sv
// rtd_antenna_model: antenna network seen at the two driver pins
// assumes pin carriers on the block clock; lines have no pull
`timescale 1ns/1ps
module rtd_antenna_model (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire rtd_pkg::rtd_pin_t first_driver_pin,
    input  wire rtd_pkg::rtd_pin_t second_driver_pin,
    output logic                   first_line,
    output logic                   second_line
);
    logic first_float_q;
    logic second_float_q;

    // ==========================================================
    // released line wanders, new value every cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            first_float_q  <= 1'b0;
            second_float_q <= 1'b1;
        end else begin
            first_float_q  <= ~first_line;
            second_float_q <= ~second_line;
        end
    end

    assign first_line  = first_driver_pin.oe ? first_driver_pin.o
                                             : first_float_q;
    assign second_line = second_driver_pin.oe ? second_driver_pin.o
                                              : second_float_q;
endmodule // rtd_antenna_model

// ### bench/tb.sv
// tb: self-checking bench for the carrier driver control block
// assumes rtd_pkg, rtd_core and the antenna model compile first
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } rtd_reg_row_t;
    typedef struct packed {
        logic [7:0] mode;
        logic       oe;
        logic       lines;
        logic [3:0] hi1;
        logic [3:0] dif;
    } rtd_pin_row_t;

    logic                  clock = 1'b0;
    logic                  rst_n = 1'b0;
    rtd_pkg::rtd_reg_req_t reg_req = '0;
    logic                  env = 1'b0;
    logic                  ext = 1'b0;
    logic [7:0]            reg_rdata;
    rtd_pkg::rtd_pin_t     pin1;
    rtd_pkg::rtd_pin_t     pin2;
    rtd_pkg::rtd_level_t   level;
    logic                  line1;
    logic                  line2;
    int                    miscompares = 0;
    int                    num_checks = 0;
    int                    cycles = 0;
    int                    hi;
    int                    df;
    rtd_reg_row_t          regs [5];
    rtd_pin_row_t          pins [11];
    logic [10:0]           mv [4];

    always #5 clock = ~clock;

    rtd_core dut_u (
        .clock                    (clock),
        .rst_n                    (rst_n),
        .reg_req                  (reg_req),
        .reg_rdata                (reg_rdata),
        .internal_envelope_signal (env),
        .external_signal_input    (ext),
        .first_driver_pin         (pin1),
        .second_driver_pin        (pin2),
        .level                    (level)
    );
    rtd_antenna_model ant_u (
        .clock             (clock),
        .rst_n             (rst_n),
        .first_driver_pin  (pin1),
        .second_driver_pin (pin2),
        .first_line        (line1),
        .second_line       (line2)
    );

    // ==========================================================
    // shared tasks
    task automatic tick(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(string what, logic [10:0] seen, logic [10:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        reg_req.wr    <= 1'b1;
        reg_req.addr  <= a;
        reg_req.wdata <= d;
        @(posedge clock);
        reg_req.wr <= 1'b0;
        tick(3);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clock);
        reg_req.rd   <= 1'b1;
        reg_req.addr <= a;
        @(posedge clock);
        reg_req.rd <= 1'b0;
        tick(1);
        chk("reg_rdata", 11'(reg_rdata), 11'(exp));
    endtask
    task automatic drive_env(logic v);
        @(posedge clock);
        env <= v;
    endtask
    task automatic test_done();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            test_done();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        regs = '{'{8'h28, 8'hFF, 8'hCF}, '{8'h29, 8'hFF, 8'hDF},
                 '{8'h2A, 8'hFF, 8'hFF}, '{8'h2B, 8'hFF, 8'h00},
                 '{8'h28, 8'h30, 8'h00}};
        // style codes 3 and 6 are never written
        pins = '{'{8'h0A, 1'b1, 1'b1, 4'h3, 4'h0},
                 '{8'h4A, 1'b1, 1'b1, 4'h3, 4'h6},
                 '{8'h8A, 1'b1, 1'b1, 4'h3, 4'h6},
                 '{8'hCA, 1'b1, 1'b1, 4'h3, 4'h0},
                 '{8'h0C, 1'b1, 1'b1, 4'h0, 4'h0},
                 '{8'h0D, 1'b1, 1'b1, 4'h6, 4'h0},
                 '{8'h4C, 1'b1, 1'b1, 4'h6, 4'h6},
                 '{8'h8D, 1'b1, 1'b1, 4'h6, 4'h6},
                 '{8'h08, 1'b0, 1'b0, 4'h0, 4'h0},
                 '{8'h02, 1'b0, 1'b0, 4'h0, 4'h0},
                 '{8'h0F, 1'b0, 1'b0, 4'h0, 4'h0}};
        mv = '{rtd_pkg::REDUCE_MV_0, rtd_pkg::REDUCE_MV_1,
               rtd_pkg::REDUCE_MV_2, rtd_pkg::REDUCE_MV_3};
        tick(4);
        rst_n <= 1'b1;
        tick(1);
        chk("pins_oe", 11'({pin1.oe, pin2.oe}), 11'h000);
        chk("level_mv", level.reduction_mv, rtd_pkg::REDUCE_MV_0);
        chk("resid_rst", 11'(level.residual_carrier), 11'h000);
        chk("swing_rst", 11'(level.full_swing), 11'h000);
        chk("mod_rst", 11'(level.modulating), 11'h000);
        rd(8'h28, 8'h00);
        rd(8'h29, 8'h00);
        rd(8'h2A, 8'h00);
        foreach (regs[i]) begin
            wr(regs[i].addr, regs[i].wdata);
            rd(regs[i].addr, regs[i].rexp);
        end
        foreach (pins[i]) begin
            wr(8'h28, pins[i].mode);
            hi = 0;
            df = 0;
            repeat (6) begin
                chk("oe1", 11'(pin1.oe), 11'(pins[i].oe));
                chk("oe2", 11'(pin2.oe), 11'(pins[i].oe));
                hi += int'(line1 === 1'b1);
                df += int'((line1 ^ line2) === 1'b1);
                tick(1);
            end
            if (pins[i].lines) begin
                chk("line1_high", 11'(hi), 11'(pins[i].hi1));
                chk("line_diff", 11'(df), 11'(pins[i].dif));
            end
        end
        wr(8'h28, 8'h09);
        hi = 0;
        df = 0;
        repeat (12) begin
            hi += int'(pin1.oe === 1'b1);
            df += int'(pin1.o !== 1'b0);
            tick(1);
        end
        chk("drain_oe", 11'(hi), 11'h006);
        chk("drain_o", 11'(df), 11'h000);
        for (int c = 0; c < 4; c++) begin
            wr(8'h29, {2'(c), 6'h15});
            wr(8'h2A, 8'h00);
            chk("reduction", level.reduction_mv, mv[c]);
            chk("residual", 11'(level.residual_carrier), 11'h015);
            wr(8'h2A, 8'h08);
            chk("max_amp", level.reduction_mv, rtd_pkg::REDUCE_MV_NONE);
            chk("full_swing", 11'(level.full_swing), 11'h001);
        end
        drive_env(1'b1);
        wr(8'h2A, 8'h00);
        chk("mod_none", 11'(level.modulating), 11'h000);
        wr(8'h2A, 8'h01);
        chk("mod_env", 11'(level.modulating), 11'h001);
        drive_env(1'b0);
        tick(1);
        chk("mod_env_off", 11'(level.modulating), 11'h000);
        wr(8'h2A, 8'h05);
        chk("mod_inv", 11'(level.modulating), 11'h001);
        wr(8'h2A, 8'h07);
        chk("mod_rsvd", 11'(level.modulating), 11'h000);
        wr(8'h2A, 8'h02);
        @(posedge clock);
        ext <= 1'b1;
        tick(3);
        chk("mod_ext", 11'(level.modulating), 11'h001);
        @(posedge clock);
        ext <= 1'b0;
        tick(3);
        chk("mod_ext_off", 11'(level.modulating), 11'h000);
        wr(8'h2A, 8'h21);
        drive_env(1'b1);
        drive_env(1'b0);
        tick(6);
        chk("guard2_on", 11'(level.modulating), 11'h001);
        tick(8);
        chk("guard2_off", 11'(level.modulating), 11'h000);
        wr(8'h2A, 8'hF1);
        drive_env(1'b1);
        drive_env(1'b0);
        tick(84);
        chk("guard15_on", 11'(level.modulating), 11'h001);
        tick(16);
        chk("guard15_off", 11'(level.modulating), 11'h000);
        // second reset in mid-run clears the written registers
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(1);
        chk("pins_oe_rst2", 11'({pin1.oe, pin2.oe}), 11'h000);
        rd(8'h29, 8'h00);
        rd(8'h2A, 8'h00);
        test_done();
    end
endmodule // tb
